// ===== sfsr_pkg.sv
/*
 Shared constants for the serial flash status and read command block:
 opcodes, status word layout, phase lengths, state codes and timing.
 Assumes a single 200 MHz system clock in the block that imports it.
*/
package sfsr_pkg;
   // Opcodes
   localparam logic [7:0] OP_WRITE_ENABLE = 8'h06;
   localparam logic [7:0] OP_STATUS_WRITE = 8'h01;
   localparam logic [7:0] OP_READY_POLL = 8'h25;
   localparam logic [7:0] OP_READ = 8'h03;
   localparam logic [7:0] OP_FAST_READ = 8'h0B;
   localparam logic [7:0] OP_DUAL_OUT = 8'h3B;
   localparam logic [7:0] OP_DUAL_IO = 8'hBB;
   localparam logic [7:0] OP_QUAD_OUT = 8'h6B;
   localparam logic [7:0] OP_ERASE_SUSPEND = 8'h75;
   localparam logic [7:0] OP_PROGRAM_SUSPEND = 8'hB0;
   localparam logic [7:0] OP_RESUME_A = 8'h7A;
   localparam logic [7:0] OP_RESUME_B = 8'h30;

   // Status word bit positions
   localparam int ST_BUSY = 0;
   localparam int ST_WEL = 1;
   localparam int ST_PROTECT_MODE_LOWER_BIT = 7;
   localparam int ST_PROTECT_MODE_UPPER_BIT = 8;
   localparam int ST_QE = 9;
   localparam int ST_PSUS = 10;
   localparam int ST_CMP = 14;
   localparam int ST_ESUS = 15;
   localparam logic [15:0] STATUS_RESET = 16'h0000;

   // Phase lengths, in bits or clocks
   localparam logic [4:0] OPCODE_BITS = 5'h08;
   localparam logic [4:0] ADDR_BITS = 5'h18;
   localparam logic [4:0] MODE_CLOCKS = 5'h04;
   localparam logic [4:0] DUMMY_CLOCKS = 5'h08;
   localparam logic [4:0] SW_SHORT = 5'h08;
   localparam logic [4:0] SW_LONG = 5'h10;
   localparam logic [4:0] SW_OVER = 5'h11;
   localparam logic [3:0] BYTE_BITS = 4'h8;
   localparam logic [1:0] CONT_KEEP = 2'h2;

   // Timing
   localparam int CLK_PERIOD_NS = 5;
   localparam int STATUS_WRITE_TIME_NS = 8000000;
   localparam int STATUS_WRITE_CYCLES = STATUS_WRITE_TIME_NS / CLK_PERIOD_NS;

   typedef enum logic [7:0] {
      S_OPCODE = 8'h01,
      S_ADDR = 8'h02,
      S_MODE = 8'h04,
      S_DUMMY = 8'h08,
      S_DATA = 8'h10,
      S_POLL = 8'h20,
      S_SWDATA = 8'h40,
      S_TAIL = 8'h80
   } sfsr_state_e;
endpackage

// ===== sfsr_core.sv
/*
 Serial flash command engine: status word, ready polling, status write,
 and single, fast, dual-output, dual-I/O and quad-output reads.
 Assumes pins come from outside the sys_clk domain and that an external
 byte array answers each rd_req with one rd_valid pulse.
*/
//
// Overview of operation
// - Suspend commands set matching suspend flag
// - Resume or reset clears both suspend flags
// - Polling opcode; later input bits ignored
// - Polling drives busy flag continuously on output
// - Output falls when busy falls
// - Chip select high ends polling, floats output
// - Status write refused without write enable latch
// - Status write keeps suspend, latch, busy bits
// - Status write needs exactly 8 or 16 bits
// - Eight-bit write clears complement, quad, upper protect
// - Valid write starts timed busy, then clears latch
// - Hardware protected mode blocks status writes
// - Read: opcode, address in; data on falling
// - Address increments, wraps, stops on chip select
// - Fast read takes one dummy byte
// - Multi-line and fast reads rejected while busy
// - Dual output: address, 8 dummies, two lines
// - Dual I/O: address, dummies, data two lines
// - Mode bits 10 skip next opcode
// - Other mode bits require full opcode next
// - Quad output: address, 8 dummies, four lines
// - Framed write enable command sets latch
// - Quad enable turns protect pin into data
`timescale 1ns/1ps
module sfsr_core
   import sfsr_pkg::*;
#(
   parameter int MEM_ADDR_W = 16,
   parameter int STATUS_WRITE_CYC = STATUS_WRITE_CYCLES
) (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic reset_n,
   // Serial pins
   input wire logic cs_n,
   input wire logic sclk,
   input wire logic data_line_zero_in,
   output logic data_line_zero_out,
   output logic data_line_zero_oe_n,
   input wire logic data_line_one_in,
   output logic data_line_one_out,
   output logic data_line_one_oe_n,
   input wire logic data_line_two_in,
   output logic data_line_two_out,
   output logic data_line_two_oe_n,
   input wire logic data_line_three_in,
   output logic data_line_three_out,
   output logic data_line_three_oe_n,
   // Array fetch port
   output logic rd_req,
   output logic [MEM_ADDR_W-1:0] rd_addr,
   output logic rd_ready,
   input wire logic rd_valid,
   input wire logic [7:0] rd_data,
   // Status word
   output logic [15:0] status_word
);
   localparam int TW_W = $clog2(STATUS_WRITE_CYC + 1);

   logic [5:0] sync1, sync2, next_sync1, next_sync2;
   logic sclk_q, cs_q, next_sclk_q, next_cs_q;
   sfsr_state_e state, next_state;
   logic [7:0] opcode, next_opcode, mode_sr, next_mode_sr;
   logic [7:0] out_sr, next_out_sr;
   logic [4:0] cnt, next_cnt;
   logic [23:0] addr, next_addr;
   logic [15:0] sw_sr, next_sw_sr, status, next_status;
   logic [3:0] out_left, next_out_left, dout, next_dout, doe_n, next_doe_n;
   logic extra, next_extra, cont_mode, next_cont_mode;
   logic fetching, next_fetching, pending, next_pending, drop, next_drop;
   logic [TW_W-1:0] timer, next_timer;
   logic [MEM_ADDR_W-1:0] fetch_addr, next_fetch_addr, next_rd_addr;
   logic next_rd_req, next_rd_ready;
   logic [MEM_ADDR_W-1:0] next_fetch_ptr;
   logic [7:0] buf_mem [2];
   logic [7:0] next_buf [2];
   logic wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
   logic [1:0] count, next_count;

   logic rise, fall, cs_low, cs_rise, wp_level, prot, push, pop;
   logic [7:0] op, cur, lo;
   logic [23:0] a_new;
   logic [3:0] left_base;

   assign rise = sync2[4] & ~sclk_q;
   assign fall = ~sync2[4] & sclk_q;
   assign cs_low = ~sync2[5];
   assign cs_rise = sync2[5] & ~cs_q;
   // Protect pin is a data line once quad is enabled
   assign wp_level = status[ST_QE] | sync2[2];
   assign prot = status[ST_PROTECT_MODE_UPPER_BIT] | (status[ST_PROTECT_MODE_LOWER_BIT] & ~wp_level);

   always_comb begin
      next_sync1 = {cs_n, sclk, data_line_three_in, data_line_two_in,
                    data_line_one_in, data_line_zero_in};
      next_sync2 = sync1;
      next_sclk_q = sync2[4];
      next_cs_q = sync2[5];
      next_state = state;
      next_opcode = opcode;
      next_mode_sr = mode_sr;
      next_out_sr = out_sr;
      next_cnt = cnt;
      next_addr = addr;
      next_sw_sr = sw_sr;
      next_status = status;
      next_out_left = out_left;
      next_dout = dout;
      next_doe_n = doe_n;
      next_extra = extra;
      next_cont_mode = cont_mode;
      next_fetching = fetching;
      next_timer = timer;
      next_fetch_addr = fetch_addr;
      op = {opcode[6:0], sync2[0]};
      cur = out_sr;
      lo = sw_sr[7:0];
      a_new = addr;
      left_base = out_left;
      pop = 1'b0;
      // Timed status write cycle
      if (status[ST_BUSY]) begin
         if (timer == '0) begin
            next_status[ST_BUSY] = 1'b0;
            next_status[ST_WEL] = 1'b0;
         end else begin
            next_timer = timer - 1'b1;
         end
      end
      if (!cs_low) begin
         next_doe_n = 4'hF;
         if (cs_rise) begin
            if (state == S_TAIL && !extra && opcode == OP_WRITE_ENABLE) begin
               next_status[ST_WEL] = 1'b1;
            end
            if (state == S_SWDATA && (cnt == SW_SHORT || cnt == SW_LONG)
                && status[ST_WEL] && !prot && !status[ST_BUSY]) begin
               lo = (cnt == SW_SHORT) ? sw_sr[7:0] : sw_sr[15:8];
               next_status[7:2] = lo[7:2];
               if (cnt == SW_SHORT) begin
                  next_status[ST_CMP] = 1'b0;
                  next_status[ST_QE] = 1'b0;
                  next_status[ST_PROTECT_MODE_UPPER_BIT] = 1'b0;
               end else begin
                  next_status[ST_CMP] = sw_sr[6];
                  next_status[13:11] = status[13:11] | sw_sr[5:3];
                  next_status[ST_QE] = sw_sr[1];
                  next_status[ST_PROTECT_MODE_UPPER_BIT] = sw_sr[0];
               end
               next_status[ST_BUSY] = 1'b1;
               next_timer = TW_W'(STATUS_WRITE_CYC - 1);
            end
         end
         // Continuous read resumes at the address phase
         next_state = cont_mode ? S_ADDR : S_OPCODE;
         next_cnt = '0;
         next_extra = 1'b0;
         next_out_left = '0;
         next_fetching = 1'b0;
      end else if (rise) begin
         case (state)
            S_OPCODE: begin
               next_opcode = op;
               next_cnt = cnt + 5'h01;
               if (cnt == OPCODE_BITS - 5'h01) begin
                  next_cnt = '0;
                  next_state = S_TAIL;
                  next_extra = 1'b1;
                  case (op)
                     OP_WRITE_ENABLE: next_extra = 1'b0;
                     OP_STATUS_WRITE: next_state = S_SWDATA;
                     OP_READY_POLL: next_state = S_POLL;
                     OP_READ: next_state = S_ADDR;
                     OP_FAST_READ, OP_DUAL_OUT, OP_DUAL_IO: begin
                        if (!status[ST_BUSY]) begin
                           next_state = S_ADDR;
                        end
                     end
                     OP_QUAD_OUT: begin
                        if (!status[ST_BUSY] && status[ST_QE]) begin
                           next_state = S_ADDR;
                        end
                     end
                     OP_ERASE_SUSPEND: next_status[ST_ESUS] = 1'b1;
                     OP_PROGRAM_SUSPEND: next_status[ST_PSUS] = 1'b1;
                     OP_RESUME_A, OP_RESUME_B: begin
                        next_status[ST_ESUS] = 1'b0;
                        next_status[ST_PSUS] = 1'b0;
                     end
                     default: next_extra = 1'b1;
                  endcase
               end
            end
            S_ADDR: begin
               if (opcode == OP_DUAL_IO) begin
                  a_new = {addr[21:0], sync2[1], sync2[0]};
                  next_cnt = cnt + 5'h02;
               end else begin
                  a_new = {addr[22:0], sync2[0]};
                  next_cnt = cnt + 5'h01;
               end
               next_addr = a_new;
               if (next_cnt == ADDR_BITS) begin
                  next_cnt = '0;
                  next_fetch_addr = a_new[MEM_ADDR_W-1:0];
                  next_fetching = 1'b1;
                  if (opcode == OP_READ) begin
                     next_state = S_DATA;
                  end else if (opcode == OP_DUAL_IO) begin
                     next_state = S_MODE;
                  end else begin
                     next_state = S_DUMMY;
                  end
               end
            end
            S_MODE: begin
               next_mode_sr = {mode_sr[5:0], sync2[1], sync2[0]};
               next_cnt = cnt + 5'h01;
               if (cnt == MODE_CLOCKS - 5'h01) begin
                  next_cont_mode = (mode_sr[3:2] == CONT_KEEP);
                  next_state = S_DUMMY;
               end
            end
            S_DUMMY: begin
               next_cnt = cnt + 5'h01;
               if (cnt == DUMMY_CLOCKS - 5'h01) begin
                  next_cnt = '0;
                  next_state = S_DATA;
               end
            end
            S_SWDATA: begin
               next_sw_sr = {sw_sr[14:0], sync2[0]};
               next_cnt = (cnt == SW_OVER) ? SW_OVER : cnt + 5'h01;
            end
            S_TAIL: next_extra = 1'b1;
            default: ;
         endcase
      end else if (fall && state == S_DATA) begin
         if (out_left == '0) begin
            cur = buf_mem[rd_ptr];
            pop = (count != 2'h0);
            left_base = BYTE_BITS;
         end
         case (opcode)
            OP_DUAL_OUT, OP_DUAL_IO: begin
               next_dout[1:0] = cur[7:6];
               next_doe_n = 4'b1100;
               next_out_sr = {cur[5:0], 2'b00};
               next_out_left = left_base - 4'h2;
            end
            OP_QUAD_OUT: begin
               next_dout = cur[7:4];
               next_doe_n = 4'b0000;
               next_out_sr = {cur[3:0], 4'h0};
               next_out_left = left_base - 4'h4;
            end
            default: begin
               next_dout[1] = cur[7];
               next_doe_n = 4'b1101;
               next_out_sr = {cur[6:0], 1'b0};
               next_out_left = left_base - 4'h1;
            end
         endcase
      end
      if (cs_low && state == S_POLL) begin
         next_dout[1] = status[ST_BUSY];
         next_doe_n = 4'b1101;
      end
   end

   // Two-entry byte buffer between array and output shifter
   always_comb begin
      push = rd_valid & rd_ready & ~drop;
      next_buf = buf_mem;
      next_wr_ptr = wr_ptr;
      next_rd_ptr = rd_ptr;
      next_count = count;
      next_pending = pending;
      next_drop = drop;
      next_rd_req = 1'b0;
      next_rd_addr = rd_addr;
      if (rd_valid) begin
         next_pending = 1'b0;
         next_drop = 1'b0;
      end
      if (push) begin
         next_buf[wr_ptr] = rd_data;
         next_wr_ptr = ~wr_ptr;
      end
      if (pop) begin
         next_rd_ptr = ~rd_ptr;
      end
      next_count = count + {1'b0, push} - {1'b0, pop};
      if (!cs_low) begin
         next_count = '0;
         next_wr_ptr = 1'b0;
         next_rd_ptr = 1'b0;
         next_drop = (pending | drop) & ~rd_valid;
      end else if (fetching && !next_pending && !next_drop
                   && next_count != 2'h2) begin
         next_rd_req = 1'b1;
         next_rd_addr = fetch_addr;
         next_pending = 1'b1;
      end
      next_rd_ready = (next_count != 2'h2);
      // Fetch address wraps to zero past the top of the array
      next_fetch_ptr = next_rd_req ? fetch_addr + 1'b1 : next_fetch_addr;
   end

   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         sync1 <= 6'h20;
         sync2 <= 6'h20;
         sclk_q <= 1'b0;
         cs_q <= 1'b1;
         state <= S_OPCODE;
         opcode <= 8'h00;
         mode_sr <= 8'h00;
         out_sr <= 8'h00;
         cnt <= 5'h00;
         addr <= 24'h000000;
         sw_sr <= 16'h0000;
         status <= STATUS_RESET;
         out_left <= 4'h0;
         dout <= 4'h0;
         doe_n <= 4'hF;
         extra <= 1'b0;
         cont_mode <= 1'b0;
         fetching <= 1'b0;
         pending <= 1'b0;
         drop <= 1'b0;
         timer <= '0;
         fetch_addr <= '0;
         rd_req <= 1'b0;
         rd_addr <= '0;
         rd_ready <= 1'b1;
         buf_mem[0] <= 8'h00;
         buf_mem[1] <= 8'h00;
         wr_ptr <= 1'b0;
         rd_ptr <= 1'b0;
         count <= 2'h0;
      end else begin
         sync1 <= next_sync1;
         sync2 <= next_sync2;
         sclk_q <= next_sclk_q;
         cs_q <= next_cs_q;
         state <= next_state;
         opcode <= next_opcode;
         mode_sr <= next_mode_sr;
         out_sr <= next_out_sr;
         cnt <= next_cnt;
         addr <= next_addr;
         sw_sr <= next_sw_sr;
         status <= next_status;
         out_left <= next_out_left;
         dout <= next_dout;
         doe_n <= next_doe_n;
         extra <= next_extra;
         cont_mode <= next_cont_mode;
         fetching <= next_fetching;
         pending <= next_pending;
         drop <= next_drop;
         timer <= next_timer;
         fetch_addr <= next_fetch_ptr;
         rd_req <= next_rd_req;
         rd_addr <= next_rd_addr;
         rd_ready <= next_rd_ready;
         buf_mem <= next_buf;
         wr_ptr <= next_wr_ptr;
         rd_ptr <= next_rd_ptr;
         count <= next_count;
      end
   end

   assign data_line_zero_out = dout[0];
   assign data_line_one_out = dout[1];
   assign data_line_two_out = dout[2];
   assign data_line_three_out = dout[3];
   assign data_line_zero_oe_n = doe_n[0];
   assign data_line_one_oe_n = doe_n[1];
   assign data_line_two_oe_n = doe_n[2];
   assign data_line_three_oe_n = doe_n[3];
   assign status_word = status;
endmodule

// ===== sfsr_asserts.sv
/*
 Pin and status checker for sfsr_core.
 Assumes a status write time of at least nine sys_clk cycles.
*/
`timescale 1ns/1ps
module sfsr_asserts
   import sfsr_pkg::*;
(
   // Clock and reset
   input wire logic sys_clk,
   input wire logic reset_n,
   // Pins
   input wire logic cs_n,
   input wire logic data_line_zero_oe_n,
   input wire logic data_line_one_out,
   input wire logic data_line_one_oe_n,
   input wire logic data_line_two_oe_n,
   input wire logic data_line_three_oe_n,
   // Fetch and status
   input wire logic rd_req,
   input wire logic [15:0] status_word
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!reset_n);
   sequence s_idle; cs_n [*6]; endsequence
   sequence s_wr_go; $rose(status_word[ST_BUSY]); endsequence
   property p_release;
      s_idle |-> data_line_zero_oe_n && data_line_one_oe_n &&
         data_line_two_oe_n && data_line_three_oe_n;
   endproperty
   property p_stop; s_idle |-> !rd_req; endproperty
   property p_dual; !data_line_zero_oe_n |-> !data_line_one_oe_n; endproperty
   property p_quad;
      !data_line_three_oe_n |-> !data_line_two_oe_n && !data_line_zero_oe_n;
   endproperty
   property p_quad_en; !data_line_two_oe_n |-> status_word[ST_QE]; endproperty
   property p_wel_first; s_wr_go |-> status_word[ST_WEL]; endproperty
   property p_keep;
      s_wr_go |-> $stable({status_word[ST_ESUS], status_word[ST_PSUS]});
   endproperty
   property p_hold; s_wr_go |=> status_word[ST_BUSY] [*8]; endproperty
   property p_done; $fell(status_word[ST_BUSY]) |-> !status_word[ST_WEL];
   endproperty
   property p_poll_fall;
      $fell(status_word[ST_BUSY]) && !cs_n && !data_line_one_oe_n |->
         ##[1:3] !data_line_one_out;
   endproperty
   a_release: assert property (p_release) else $error("line driven idle");
   a_stop: assert property (p_stop) else $error("fetch while idle");
   a_dual: assert property (p_dual) else $error("line zero alone");
   a_quad: assert property (p_quad) else $error("quad lines split");
   a_quad_en: assert property (p_quad_en) else $error("quad off");
   a_wel_first: assert property (p_wel_first) else $error("no latch");
   a_keep: assert property (p_keep) else $error("suspend changed");
   a_hold: assert property (p_hold) else $error("busy too short");
   a_done: assert property (p_done) else $error("latch kept");
   a_poll_fall: assert property (p_poll_fall) else $error("poll stuck");
endmodule

// ===== sfsr_host.sv
/*
 Host serial controller model in clock mode 0, most significant bit first.
 Assumes its tasks are called 1 ns after a rising sys_clk edge.
*/
`timescale 1ns/1ps
module sfsr_host (
   // Resolved data lines
   input wire logic [3:0] line,
   // Host drive
   output logic cs_n,
   output logic sclk,
   output logic [3:0] drv_val,
   output logic [3:0] drv_en
);
   initial begin
      cs_n = 1'b1;
      sclk = 1'b0;
      drv_val = 4'h0;
      drv_en = 4'h0;
   end
   task automatic open_f;
      cs_n = 1'b0;
      #80;
   endtask
   // Lines released before chip select rises
   task automatic close_f;
      drv_en = 4'h0;
      #80;
      cs_n = 1'b1;
      #160;
   endtask
   task automatic xfer(input int n, input int w, input logic drv,
         input logic [31:0] v, output logic [31:0] r);
      logic [3:0] m;
      m = (w == 1) ? 4'h1 : (w == 2) ? 4'h3 : 4'hF;
      r = 32'h0;
      for (int i = n - 1; i >= 0; i--) begin
         drv_val = 4'(v >> (i * w)) & m;
         drv_en = drv ? m : 4'h0;
         #80;
         sclk = 1'b1;
         r = (w == 1) ? {r[30:0], line[1]} : (r << w) | 32'(line & m);
         #80;
         sclk = 1'b0;
      end
   endtask
endmodule

// ===== serial_flash_status_and_read_commands_tb.sv
/*
 Self-checking bench for sfsr_core with host model and byte array.
 Assumes a short status write time set through the parameter.
*/
`timescale 1ns/1ps
module serial_flash_status_and_read_commands_tb;
   import sfsr_pkg::*;
   localparam int SWC = 2000;
   localparam logic [7:0] RD_OPS [5] = '{OP_READ, OP_FAST_READ,
      OP_DUAL_OUT, OP_DUAL_IO, OP_QUAD_OUT};
   localparam logic [7:0] SUS_OPS [5] = '{OP_ERASE_SUSPEND,
      OP_PROGRAM_SUSPEND, OP_RESUME_A, OP_ERASE_SUSPEND, OP_RESUME_B};
   localparam logic [15:0] SUS_EXP [5] = '{16'h8000, 16'h8400, 16'h0000,
      16'h8000, 16'h0000};
   logic sys_clk, reset_n, cs_n, sclk, tog, wp_pin, rd_req, rd_ready;
   logic rd_valid;
   logic [7:0] rd_data;
   logic [15:0] rd_addr, status_word, lfsr, pend;
   logic [3:0] d_out, d_oe_n, h_val, h_en, line;
   int error_cnt, total_checks, lat;
   logic [31:0] rsp;
   function automatic logic [7:0] mem_byte(input logic [15:0] a);
      return a[7:0] ^ a[15:8] ^ 8'h5A;
   endfunction
   function automatic logic [15:0] lfsr_next(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   function automatic logic [15:0] sw_next(input logic [15:0] o, v,
         input logic s);
      if (s) return {o[15], 1'b0, o[13:11], o[10], 2'b00, v[7:2], 2'b00};
      return {o[15], v[14], o[13:11] | v[13:11], o[10], v[9:2], 2'b00};
   endfunction
   sfsr_host hst (.line(line), .cs_n(cs_n), .sclk(sclk), .drv_val(h_val),
      .drv_en(h_en));
   sfsr_core #(.MEM_ADDR_W(16), .STATUS_WRITE_CYC(SWC)) uut (
      .sys_clk(sys_clk), .reset_n(reset_n), .cs_n(cs_n), .sclk(sclk),
      .data_line_zero_in(line[0]), .data_line_zero_out(d_out[0]),
      .data_line_zero_oe_n(d_oe_n[0]), .data_line_one_in(line[1]),
      .data_line_one_out(d_out[1]), .data_line_one_oe_n(d_oe_n[1]),
      .data_line_two_in(line[2]), .data_line_two_out(d_out[2]),
      .data_line_two_oe_n(d_oe_n[2]), .data_line_three_in(line[3]),
      .data_line_three_out(d_out[3]), .data_line_three_oe_n(d_oe_n[3]),
      .rd_req(rd_req), .rd_addr(rd_addr), .rd_ready(rd_ready),
      .rd_valid(rd_valid), .rd_data(rd_data), .status_word(status_word));
   // Released lines other than line two toggle so stale values never pass; line two follows wp_pin
   always_comb begin
      for (int k = 0; k < 4; k++) begin
         line[k] = !d_oe_n[k] ? d_out[k] : h_en[k] ? h_val[k] :
            (k == 2) ? wp_pin : tog;
      end
   end
   // Byte array answering after one to eight cycles
   always @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         tog <= 1'b0;
         rd_valid <= 1'b0;
         rd_data <= 8'h00;
         pend <= 16'h0000;
         lat <= 0;
      end else begin
         tog <= ~tog;
         rd_valid <= 1'b0;
         if (rd_req) begin
            pend <= rd_addr;
            lat <= 1 + int'(lfsr[2:0]);
         end else if (lat > 0) begin
            lat <= lat - 1;
            rd_valid <= (lat == 1);
            rd_data <= mem_byte(pend);
         end
      end
   end
   task automatic chk(input logic [15:0] got, exp);
      total_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic complete_run;
      $display("checks %0d errors %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask
   task automatic cmd(input logic [7:0] op);
      logic [31:0] r;
      hst.open_f();
      hst.xfer(8, 1, 1'b1, 32'(op), r);
      hst.close_f();
      tick(1);
   endtask
   task automatic status_write_command(input logic [15:0] v, input int n);
      logic [31:0] r;
      hst.open_f();
      hst.xfer(8, 1, 1'b1, 32'(OP_STATUS_WRITE), r);
      hst.xfer(n, 1, 1'b1, 32'({v[7:0], v[15:8]} >> (16 - n)), r);
      hst.close_f();
      tick(1);
   endtask
   task automatic wait_idle;
      for (int i = 0; i < 3000 && status_word[ST_BUSY] !== 1'b0; i++) begin
         @(posedge sys_clk);
      end
      tick(1);
      chk({15'h0, status_word[ST_BUSY]}, 16'h0000);
   endtask
   task automatic rd(input logic [7:0] op, input logic skip,
         input logic [23:0] a, input logic [7:0] mode, input int nb,
         input logic rej);
      logic [31:0] r;
      logic [15:0] ea;
      int aw, dw, dc;
      aw = (op == OP_DUAL_IO) ? 2 : 1;
      dw = (op == OP_READ || op == OP_FAST_READ) ? 1 :
         (op == OP_QUAD_OUT) ? 4 : 2;
      dc = (op == OP_READ) ? 0 : (op == OP_DUAL_IO) ? 4 : 8;
      ea = a[15:0];
      hst.open_f();
      if (!skip) hst.xfer(8, 1, 1'b1, 32'(op), r);
      hst.xfer(24 / aw, aw, 1'b1, 32'(a), r);
      if (aw == 2) hst.xfer(4, 2, 1'b1, 32'(mode), r);
      hst.xfer(dc, aw, aw == 1, 32'h0, r);
      for (int b = 0; b < nb; b++) begin
         hst.xfer(8 / dw, dw, 1'b0, 32'h0, r);
         if (rej) chk({12'h0, d_oe_n}, 16'h000F);
         else chk({8'h0, r[7:0]}, {8'h0, mem_byte(ea)});
         ea++;
      end
      hst.close_f();
      tick(1);
   endtask
   initial begin
      sys_clk = 1'b0;
      forever #2.5 sys_clk = ~sys_clk;
   end
   initial begin
      #500000;
      error_cnt++;
      complete_run();
   end
   initial begin
      reset_n = 1'b0;
      wp_pin = 1'b1;
      lfsr = 16'h0055;
      error_cnt = 0;
      total_checks = 0;
      repeat (16) @(posedge sys_clk);
      #1;
      reset_n = 1'b1;
      tick(6);
      chk(status_word, STATUS_RESET);
      chk({11'h0, d_oe_n, rd_ready}, 16'h001F);
      for (int i = 0; i < 5; i++) begin
         cmd(SUS_OPS[i]);
         chk(status_word & 16'h8400, SUS_EXP[i]);
      end
      cmd(OP_ERASE_SUSPEND);
      reset_n = 1'b0;
      tick(2);
      reset_n = 1'b1;
      tick(6);
      chk(status_word, STATUS_RESET);
      status_write_command(16'hC67F, 16);
      tick(8);
      chk(status_word, 16'h0000);
      cmd(OP_WRITE_ENABLE);
      chk(status_word, 16'h0002);
      status_write_command(16'h0FFF, 12);
      tick(8);
      chk(status_word, 16'h0002);
      // Lock bit 11 set here must survive every later write
      status_write_command(16'hCE7F, 16);
      chk(status_word & 16'h0003, 16'h0003);
      rd(OP_FAST_READ, 1'b0, 24'h000010, 8'h00, 1, 1'b1);
      chk(status_word & 16'h0003, 16'h0003);
      wait_idle();
      chk(status_word, sw_next(16'h0002, 16'hCE7F, 1'b0));
      for (int i = 0; i < 10; i++) begin
         lfsr = lfsr_next(lfsr);
         rd(RD_OPS[i % 5], 1'b0, {8'h00, lfsr}, 8'h00, 2, 1'b0);
      end
      rd(OP_READ, 1'b0, 24'h00FFFF, 8'h00, 2, 1'b0);
      rd(OP_DUAL_IO, 1'b0, 24'h001234, 8'h20, 1, 1'b0);
      rd(OP_DUAL_IO, 1'b1, 24'h00ABCD, 8'h30, 1, 1'b0);
      rd(OP_READ, 1'b0, 24'h000777, 8'h00, 1, 1'b0);
      cmd(OP_WRITE_ENABLE);
      status_write_command(16'h0080, 8);
      hst.open_f();
      hst.xfer(8, 1, 1'b1, 32'(OP_READY_POLL), rsp);
      tick(8);
      chk({14'h0, d_oe_n[1], d_out[1]}, 16'h0001);
      wait_idle();
      tick(3);
      chk({14'h0, d_oe_n[1], d_out[1]}, 16'h0000);
      hst.close_f();
      chk({12'h0, d_oe_n}, 16'h000F);
      chk(status_word, sw_next(16'h4A7E, 16'h0080, 1'b1));
      rd(OP_QUAD_OUT, 1'b0, 24'h000020, 8'h00, 1, 1'b1);
      wp_pin = 1'b0;
      cmd(OP_WRITE_ENABLE);
      status_write_command(16'h0000, 16);
      tick(8);
      chk(status_word, 16'h0882);
      wp_pin = 1'b1;
      status_write_command(16'h0000, 16);
      wait_idle();
      chk(status_word, 16'h0800);
      complete_run();
   end
endmodule
bind sfsr_core sfsr_asserts chk (.sys_clk(sys_clk), .reset_n(reset_n),
   .cs_n(cs_n), .data_line_zero_oe_n(data_line_zero_oe_n),
   .data_line_one_out(data_line_one_out),
   .data_line_one_oe_n(data_line_one_oe_n),
   .data_line_two_oe_n(data_line_two_oe_n),
   .data_line_three_oe_n(data_line_three_oe_n), .rd_req(rd_req),
   .status_word(status_word));
